// >>> hw/rwb_device.sv
// What this block does
// - Realign parallel words after deserialization
// - One independent realigner per channel
// - Realigner runs on fabric clock domain
// - Request source: pin or fabric logic
// - Each request rising edge slips one bit
// - Never bypassed; idle path adds latency only
// - Word width of eight or ten bits
// - Counter wraps past n-1; output from stage three
// - Otherwise output spans stages two and three
// - Valid word every cycle after wrap
// - Fabric re-requests until pattern matches
// - Fabric registers incoming words before compare
// - Fabric registers request before driving it
// - Request pulse high two word periods
// - Request low at least nine periods between pulses
// - Per-channel FIFO hands words to fabric clock
// - Both FIFO clocks share one frequency
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------
module rwb_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic full, next_full, empty, next_empty;
  logic push, pop;

  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : PW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : PW'(rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
    next_full = (next_count == FULL_COUNT);
    next_empty = (next_count == '0);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      full <= next_full;
      empty <= next_empty;
    end
  end

  // Storage carries no reset; empty guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // rwb_fifo

// ------------------------------------------------------------
// Channel realigner
// ------------------------------------------------------------
module rwb_device
  import rwb_pkg::*;
#(
  parameter int unsigned DEPTH = rwb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Deserialized words
  input wire rwb_pkg::rwb_word_t rx_word_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  // Configuration
  input wire logic factor10_i,
  input wire logic align_en_i,
  input wire logic align_pin_sel_i,
  input wire logic align_pin_i,
  // Status
  output logic [rwb_pkg::CNT_W-1:0] slip_count_o,
  // Link to fabric
  rwb_link_if.dev link
);
  import rwb_pkg::*;

  // ------------------------------------------------------------
  // Clock-domain FIFO
  // ------------------------------------------------------------
  // Both sides run on clk_i: equal frequency, so only phase differs
  rwb_word_t fifo_data;
  logic fifo_valid, fifo_ready, fifo_full_n;

  rwb_fifo #(.WIDTH(WORD_MAX), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_data_i(rx_word_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(fifo_full_n),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  // Registered copy is ANDed with the live flag: ready falls in the same cycle as full,
  // but returns one cycle after full clears, which the FIFO depth absorbs
  logic rx_ready, next_rx_ready;

  // ------------------------------------------------------------
  // Bit slip
  // ------------------------------------------------------------
  function automatic rwb_word_t slip_word(input rwb_word_t newer, input rwb_word_t older,
                                          input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] n);
    rwb_word_t w;
    int unsigned src;
    w = '0;
    for (int unsigned i = 0; i < WORD_MAX; i++) begin
      src = i + cnt;
      if (i < n) begin
        if (src < n) begin
          w[i] = older[src];
        end else begin
          w[i] = newer[src - n];
        end
      end
    end
    slip_word = w;
  endfunction

  rwb_word_t stage2, stage3, next_stage2, next_stage3, out_word, next_out_word;
  logic out_valid, next_out_valid;
  logic stage2_live, stage3_live, next_stage2_live, next_stage3_live;
  logic [CNT_W-1:0] cnt, next_cnt, nbits;
  logic req, req_prev, next_req_prev, slip, take;

  assign nbits = rwb_factor(factor10_i);
  assign req = align_en_i && (align_pin_sel_i ? align_pin_i : link.align_req);
  assign slip = req && !req_prev;
  assign take = fifo_valid && (!out_valid || link.ready);
  assign fifo_ready = take;

  always_comb begin
    next_rx_ready = fifo_full_n;
    next_req_prev = req;
    next_stage2 = stage2;
    next_stage3 = stage3;
    next_out_word = out_word;
    next_out_valid = out_valid;
    next_stage2_live = stage2_live;
    next_stage3_live = stage3_live;
    next_cnt = cnt;
    if (slip) begin
      next_cnt = (cnt >= nbits - CNT_STEP) ? CNT_RESET : CNT_W'(cnt + CNT_STEP);
    end
    if (take) begin
      // Slip applies to parallel words only, stage by stage
      next_stage2 = fifo_data & rwb_mask(factor10_i);
      next_stage3 = stage2;
      next_out_word = slip_word(stage2, stage3, cnt, nbits);
      next_stage2_live = 1'b1;
      next_stage3_live = stage2_live;
      // Reset zeros in the stages must never reach the fabric as data
      next_out_valid = stage2_live && stage3_live;
    end else if (link.ready) begin
      next_out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_ready <= 1'b0;
      req_prev <= 1'b0;
      stage2 <= '0;
      stage3 <= '0;
      out_word <= '0;
      out_valid <= 1'b0;
      stage2_live <= 1'b0;
      stage3_live <= 1'b0;
      cnt <= CNT_RESET;
    end else begin
      rx_ready <= next_rx_ready;
      req_prev <= next_req_prev;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
      out_word <= next_out_word;
      out_valid <= next_out_valid;
      stage2_live <= next_stage2_live;
      stage3_live <= next_stage3_live;
      cnt <= next_cnt;
    end
  end

  assign rx_ready_o = rx_ready && fifo_full_n;
  assign slip_count_o = cnt;
  assign link.word = out_word;
  assign link.valid = out_valid;
endmodule // rwb_device
`default_nettype wire

// >>> hw/rwb_pkg.sv
package rwb_pkg;
  // ------------------------------------------------------------
  // Word geometry
  // ------------------------------------------------------------
  localparam int unsigned WORD_MAX = 10;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] FACTOR_8 = 4'h8;
  localparam logic [CNT_W-1:0] FACTOR_10 = 4'hA;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

  // ------------------------------------------------------------
  // Buffer depth in words, clock in MHz, handshake timing in word clock periods
  // ------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PULSE_PERIODS = 2;
  localparam int unsigned GAP_PERIODS = 3;
  localparam int unsigned SETTLE_WORDS = 4;
  localparam logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(PULSE_PERIODS);
  localparam logic [CNT_W-1:0] GAP_CYCLES = CNT_W'(GAP_PERIODS);
  localparam logic [CNT_W-1:0] SETTLE_COUNT = CNT_W'(SETTLE_WORDS);

  typedef logic [WORD_MAX-1:0] rwb_word_t;

  // Bits per word for the selected deserialization factor
  function automatic logic [CNT_W-1:0] rwb_factor(input logic factor10);
    rwb_factor = factor10 ? FACTOR_10 : FACTOR_8;
  endfunction

  // Mask of the live bits of a word
  function automatic rwb_word_t rwb_mask(input logic factor10);
    rwb_mask = factor10 ? 10'h3FF : 10'h0FF;
  endfunction
endpackage

// >>> hw/rwb_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rwb_link_if;
  import rwb_pkg::*;
  rwb_word_t word;
  logic valid;
  logic ready;
  logic align_req;

  modport dev (output word, output valid, input ready, input align_req);
  modport host (input word, input valid, output ready, output align_req);
endinterface
`default_nettype wire

// >>> hw/rwb_host.sv
`timescale 1ns/1ns
`default_nettype none
module rwb_host
  import rwb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  input wire logic factor10_i,
  input wire rwb_pkg::rwb_word_t pattern_i,
  // Status
  output logic locked_o,
  output logic busy_o,
  // Received words
  output rwb_pkg::rwb_word_t data_o,
  output logic data_valid_o,
  // Link to realigner
  rwb_link_if.host link
);
  import rwb_pkg::*;

  typedef enum logic [2:0] {HS_IDLE, HS_CHECK, HS_PULSE, HS_GAP, HS_SETTLE, HS_LOCKED} rwb_state_t;

  // ------------------------------------------------------------
  // Input capture
  // ------------------------------------------------------------
  rwb_word_t sync_word, next_sync_word;
  logic sync_valid, next_sync_valid;

  always_comb begin
    next_sync_valid = link.valid;
    next_sync_word = link.valid ? link.word : sync_word;
  end

  // ------------------------------------------------------------
  // Alignment sequencer
  // ------------------------------------------------------------
  // Settle lets slipped words reach the compare before a new verdict
  rwb_state_t state, next_state;
  logic [CNT_W-1:0] timer, next_timer;
  logic req, next_req, req_sync, next_req_sync;
  logic match;

  assign match = ((sync_word ^ pattern_i) & rwb_mask(factor10_i)) == '0;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_req = 1'b0;
    next_req_sync = req;
    case (state)
      HS_IDLE: begin
        if (start_i) begin
          next_state = HS_CHECK;
        end
      end
      HS_CHECK: begin
        if (sync_valid) begin
          if (match) begin
            next_state = HS_LOCKED;
          end else begin
            next_state = HS_PULSE;
            next_timer = CNT_STEP;
            next_req = 1'b1;
          end
        end
      end
      HS_PULSE: begin
        if (timer >= PULSE_CYCLES) begin
          next_state = HS_GAP;
          next_timer = CNT_RESET;
        end else begin
          next_req = 1'b1;
          next_timer = CNT_W'(timer + CNT_STEP);
        end
      end
      HS_GAP: begin
        next_timer = CNT_W'(timer + CNT_STEP);
        if (timer >= GAP_CYCLES) begin
          next_state = HS_SETTLE;
          next_timer = CNT_RESET;
        end
      end
      HS_SETTLE: begin
        if (sync_valid) begin
          next_timer = CNT_W'(timer + CNT_STEP);
          if (timer >= SETTLE_COUNT - CNT_STEP) begin
            next_state = HS_CHECK;
          end
        end
      end
      HS_LOCKED: begin
        if (start_i) begin
          next_state = HS_CHECK;
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_word <= '0;
      sync_valid <= 1'b0;
      state <= HS_IDLE;
      timer <= CNT_RESET;
      req <= 1'b0;
      req_sync <= 1'b0;
      locked_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      sync_word <= next_sync_word;
      sync_valid <= next_sync_valid;
      state <= next_state;
      timer <= next_timer;
      req <= next_req;
      req_sync <= next_req_sync;
      locked_o <= (next_state == HS_LOCKED);
      busy_o <= (next_state != HS_IDLE) && (next_state != HS_LOCKED);
    end
  end

  assign data_o = sync_word;
  assign data_valid_o = sync_valid;
  assign link.ready = 1'b1;
  assign link.align_req = req_sync;
endmodule // rwb_host
`default_nettype wire

// >>> bench/rwb_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rwb_link_properties
  import rwb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link signals
  input wire rwb_pkg::rwb_word_t word,
  input wire logic valid,
  input wire logic ready,
  input wire logic align_req
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ----
  // Link checks
  // ----
  chk_pulse_two_high: assert property ($rose(align_req) |=> align_req ##1 !align_req)
    else $error("request pulse width wrong");
  chk_gap_after_fall: assert property ($fell(align_req) |-> !align_req [*3])
    else $error("request gap too short");
  chk_gap_before_rise: assert property ($rose(align_req) |-> !$past(align_req, 2) && !$past(align_req, 3))
    else $error("request rose after short gap");
  chk_ready_held: assert property (ready)
    else $error("ready dropped");
  chk_req_idle_reset: assert property ($rose(resetn_i) |-> !align_req ##1 !align_req)
    else $error("request too early after reset");
  chk_word_latency: assert property ($rose(resetn_i) |-> !valid [*3])
    else $error("word too early after reset");
  chk_valid_stream: assert property ($rose(valid) |=> valid [*2])
    else $error("word stream broke");
  chk_req_after_word: assert property ($rose(align_req) |-> $past(valid, 3))
    else $error("request without a checked word");

  // Main scenarios
  cover property ($rose(align_req));
  cover property ($fell(align_req) ##3 !align_req);
  cover property (valid ##1 valid);
endmodule // rwb_link_properties
`default_nettype wire

// >>> bench/tb_rx_word_boundary_bit_slip.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rx_word_boundary_bit_slip;
  import rwb_pkg::*;
  // Aperiodic words, so every slip gives a distinct output
  localparam rwb_word_t P8 = 10'h0B4;
  localparam rwb_word_t P10 = 10'h2C5;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rwb_word_t rx_word = P8;
  rwb_word_t pattern = 10'h000;
  rwb_word_t data;
  logic rx_ready, locked, busy, data_valid;
  logic f10 = 1'b0;
  logic en = 1'b0;
  logic sel = 1'b1;
  logic pin = 1'b0;
  logic start = 1'b0;
  logic [CNT_W-1:0] slip;
  int err_count = 0;
  int comparisons = 0;

  always #4 clk_i = ~clk_i;

  rwb_link_if i_rwb_link_if ();
  rwb_device i_rwb_device (.clk_i(clk_i), .resetn_i(resetn_i), .rx_word_i(rx_word), .rx_valid_i(1'b1),
    .rx_ready_o(rx_ready), .factor10_i(f10), .align_en_i(en), .align_pin_sel_i(sel), .align_pin_i(pin),
    .slip_count_o(slip), .link(i_rwb_link_if.dev));
  rwb_host i_rwb_host (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start), .factor10_i(f10),
    .pattern_i(pattern), .locked_o(locked), .busy_o(busy), .data_o(data), .data_valid_o(data_valid),
    .link(i_rwb_link_if.host));
  rwb_link_properties i_rwb_link_properties (.clk_i(clk_i), .resetn_i(resetn_i), .word(i_rwb_link_if.word),
    .valid(i_rwb_link_if.valid), .ready(i_rwb_link_if.ready), .align_req(i_rwb_link_if.align_req));

  // ----
  // Helpers
  // ----
  task automatic chk_word(input rwb_word_t got, input rwb_word_t exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic rwb_word_t rot(input rwb_word_t p, input int k, input int n);
    rot = 10'h000;
    for (int i = 0; i < n; i++) begin
      rot[i] = p[(i + k) % n];
    end
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(input logic m);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    f10 <= m;
    en <= 1'b0;
    rx_word <= m ? P10 : P8;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask

  // Pin request: high for hi cycles, then low for three
  task automatic pulse(input int hi, input logic e);
    @(posedge clk_i);
    en <= e;
    pin <= 1'b1;
    repeat (hi) @(posedge clk_i);
    pin <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic slip_sweep(input logic m);
    int n;
    rwb_word_t p;
    n = m ? 10 : 8;
    p = m ? P10 : P8;
    do_reset(m);
    repeat (8) @(posedge clk_i);
    #1;
    chk_cnt(slip, 4'h0);
    chk_word(i_rwb_link_if.word, p);
    pulse(2, 1'b0);
    #1;
    chk_cnt(slip, 4'h0);
    // First request held long: a held level must still give one slip
    for (int k = 1; k <= n; k++) begin
      pulse(k == 1 ? 5 : 2, 1'b1);
      repeat (8) @(posedge clk_i);
      #1;
      chk_cnt(slip, CNT_W'(k % n));
      chk_word(i_rwb_link_if.word, rot(p, k % n, n));
    end
    chk_cnt({3'h0, rx_ready}, 4'h1);
  endtask

  task automatic host_search();
    do_reset(1'b0);
    @(posedge clk_i);
    sel <= 1'b0;
    en <= 1'b1;
    pattern <= rot(P8, 3, 8);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    for (int i = 0; i < 600 && locked !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    #1;
    if (locked !== 1'b1) begin
      err_count++;
      end_sim();
    end
    chk_cnt(slip, 4'h3);
    chk_word(data, rot(P8, 3, 8));
    chk_cnt({3'h0, data_valid}, 4'h1);
    repeat (30) @(posedge clk_i);
    #1;
    chk_cnt(slip, 4'h3);
    chk_cnt({3'h0, busy}, 4'h0);
  endtask

  // Fresh word every cycle for eight cycles: buffer and stages must replay them in order
  task automatic fifo_check();
    int m;
    m = 0;
    do_reset(1'b0);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (i < 8) begin
        rx_word <= rwb_word_t'(i + 1);
      end
      #1;
      if (m == 0 && i_rwb_link_if.word === 10'h001) begin
        m = 1;
      end
      if (m > 0 && m <= 8) begin
        chk_word(i_rwb_link_if.word, rwb_word_t'(m));
        m++;
      end
    end
    chk_cnt(CNT_W'(m - 1), 4'h8);
    chk_cnt({3'h0, i_rwb_link_if.valid}, 4'h1);
  endtask

  initial begin
    slip_sweep(1'b0);
    slip_sweep(1'b1);
    host_search();
    fifo_check();
    end_sim();
  end
endmodule // tb_rx_word_boundary_bit_slip
`default_nettype wire
